// *** rec_top.sv ***
// Regulator enable control: rails, latched straps, control and status registers
//
// Contract
// - The supply level select pin is caught once at the first wake power cycle (open 3.3 V, grounded 5 V) and held.
// - I/O rail overtemperature sends the device to STANDBY with every regulator off.
// - The first wake power cycle starts the I/O and core rail soft-start ramp of 1 ms to 2 ms.
// - An open core feedback input forces the core gate drive low and masks core overvoltage and its stage-enable reaction.
// - Core monitoring is off after reset; with unmask set, core undervoltage asserts and extends the MCU reset.
// - The tracking choice is caught during the first ramp and held afterwards.
// - The sensor rail is off at start-up; writing 1 to bit 0 of sensor control enables it and starts its ramp.
// - Sensor rail overtemperature clears sensor control bit 0 only, other rails unaffected.
// - Re-enabling needs a read of safety status one, clearing bit 2, before bit 0 is set again.
// - The sensor enable is reset only by power-on reset, not by the RESET state.
// - Sensor rail under or overvoltage during the RESET to DIAGNOSTIC self-test raises the self-test error and goes SAFE.
// - CAN rail overtemperature clears sensor control bit 4 only; the rail returns when it is set again.
`timescale 1ns/1ps
`default_nettype none
module rec_top #(
    parameter int RAMP_CYC = rec_pkg::REC_RAMP_CYC,
    parameter int RST_EXT_CYC = rec_pkg::REC_RST_EXT_CYC,
    parameter int BIST_CYC = rec_pkg::REC_BIST_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wake,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire rec_pkg::rec_pins_t pins,
    input wire logic reset_request,
    output logic io_rail_en,
    output logic io_level_5v,
    output logic core_rail_en,
    output logic core_gate_drive_en,
    output logic can_rail_en,
    output logic sensor_rail_en,
    output logic sensor_ramp_busy,
    output logic sensor_tracking,
    output logic mcu_reset_out_n,
    output logic core_ov_flag,
    output logic external_stage_enable_out,
    output logic analog_selftest_error,
    output logic irq
);
    import rec_pkg::*;

    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    rec_pins_t ps;
    logic wake_s;
    rec_sync #(.W(11)) rec_sync_inst (
        .clk(clk),
        .rst_n(rst_n),
        .d({pins, wake}),
        .q({ps, wake_s})
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        rec_state_t st;
        logic [REC_CNT_W-1:0] ramp_cnt;
        logic [REC_CNT_W-1:0] sens_cnt;
        logic [REC_CNT_W-1:0] ext_cnt;
        logic latched;
        logic lvl_open;
        logic track;
        logic [7:0] sensor_control_register;
        logic [7:0] device_config_one;
        logic sens_ot_flag;
        logic bist_err;
        logic mcu_reset_out;
        logic [3:0] irq_stat;
        logic [3:0] irq_en;
        logic [7:0] rdata;
    } rec_state_s_t;

    rec_state_s_t s_q, s_d;

    logic core_mon;
    logic core_uv_hit;
    logic [3:0] ev;

    always_comb begin
        s_d = s_q;
        core_mon = s_q.device_config_one[REC_NMASK_BIT] && !ps.core_fb_open;
        core_uv_hit = core_mon && ps.core_uv;
        ev = {ps.can_ot, ps.sens_ot, ps.io_ot, s_q.bist_err};

        // Device sequence
        unique case (s_q.st)
            REC_ST_OFF: begin
                if (wake_s) begin
                    s_d.st = REC_ST_RAMP;
                    s_d.ramp_cnt = REC_CNT_W'(RAMP_CYC);
                    if (!s_q.latched) begin
                        s_d.lvl_open = ps.level_sel_open;
                    end
                end
            end
            REC_ST_RAMP: begin
                if (!s_q.latched) begin
                    s_d.track = ps.track_high;
                end
                if (s_q.ramp_cnt != '0) begin
                    s_d.ramp_cnt = s_q.ramp_cnt - 1'b1;
                end else begin
                    s_d.latched = 1'b1;
                    s_d.st = REC_ST_RESET;
                    s_d.ext_cnt = REC_CNT_W'(RST_EXT_CYC);
                end
            end
            REC_ST_RESET: begin
                s_d.mcu_reset_out = 1'b0;
                if (s_q.ext_cnt != '0) begin
                    s_d.ext_cnt = s_q.ext_cnt - 1'b1;
                end else begin
                    s_d.st = REC_ST_DIAG;
                    s_d.ramp_cnt = REC_CNT_W'(BIST_CYC);
                end
            end
            REC_ST_DIAG: begin
                s_d.mcu_reset_out = 1'b1;
                if (s_q.ramp_cnt != '0) begin
                    s_d.ramp_cnt = s_q.ramp_cnt - 1'b1;
                    if (s_q.sensor_control_register[REC_SENS_EN_BIT] && (ps.sens_uv || ps.sens_ov)) begin
                        s_d.bist_err = 1'b1;
                        s_d.st = REC_ST_SAFE;
                    end
                end else begin
                    s_d.st = REC_ST_ACTIVE;
                end
            end
            REC_ST_ACTIVE: begin
                s_d.mcu_reset_out = 1'b1;
            end
            REC_ST_SAFE: begin
                s_d.mcu_reset_out = 1'b0;
            end
            REC_ST_STANDBY: begin
                s_d.mcu_reset_out = 1'b0;
                if (!wake_s) begin
                    s_d.st = REC_ST_OFF;
                end
            end
        endcase

        // Reset entry and extension; a failed self-test keeps SAFE
        if ((s_q.st == REC_ST_DIAG || s_q.st == REC_ST_ACTIVE) &&
            (core_uv_hit || reset_request) && s_d.st != REC_ST_SAFE) begin
            s_d.st = REC_ST_RESET;
            s_d.mcu_reset_out = 1'b0;
            s_d.ext_cnt = REC_CNT_W'(RST_EXT_CYC);
        end else if (s_q.st == REC_ST_RESET && core_uv_hit) begin
            s_d.st = REC_ST_RESET;
            s_d.mcu_reset_out = 1'b0;
            s_d.ext_cnt = REC_CNT_W'(RST_EXT_CYC);
        end

        // Sensor ramp counter
        if (s_q.sens_cnt != '0) begin
            s_d.sens_cnt = s_q.sens_cnt - 1'b1;
        end

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                REC_SENSOR_CONTROL_REGISTER_ADDR: begin
                    if (reg_wdata[REC_SENS_EN_BIT] && !s_q.sensor_control_register[REC_SENS_EN_BIT] &&
                        !s_q.sens_ot_flag) begin
                        s_d.sens_cnt = REC_CNT_W'(RAMP_CYC);
                    end
                    s_d.sensor_control_register = reg_wdata;
                    if (s_q.sens_ot_flag) begin
                        s_d.sensor_control_register[REC_SENS_EN_BIT] = 1'b0;
                    end
                end
                REC_DEVICE_CONFIG_ONE_ADDR: s_d.device_config_one = reg_wdata;
                REC_IRQ_EN_ADDR: s_d.irq_en = reg_wdata[3:0];
                REC_IRQ_CLR_ADDR: s_d.irq_stat = s_q.irq_stat & ~reg_wdata[3:0];
                default: ;
            endcase
        end

        // Register reads, data stand one cycle later
        s_d.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                REC_SENSOR_CONTROL_REGISTER_ADDR: s_d.rdata = s_q.sensor_control_register;
                REC_DEVICE_CONFIG_ONE_ADDR: s_d.rdata = s_q.device_config_one;
                REC_SAFETY_STAT1_ADDR: begin
                    s_d.rdata = 8'h00;
                    s_d.rdata[REC_SENS_OT_BIT] = s_q.sens_ot_flag;
                    s_d.sens_ot_flag = 1'b0;
                end
                REC_STATUS_ADDR: s_d.rdata = {1'b0, s_q.st, s_q.bist_err, s_q.track,
                                              s_q.lvl_open, s_q.mcu_reset_out};
                REC_IRQ_STAT_ADDR: s_d.rdata = {4'h0, s_q.irq_stat};
                REC_IRQ_EN_ADDR: s_d.rdata = {4'h0, s_q.irq_en};
                default: s_d.rdata = 8'h00;
            endcase
        end

        // Rail overtemperature, set wins over clear
        if (ps.sens_ot) begin
            s_d.sensor_control_register[REC_SENS_EN_BIT] = 1'b0;
            s_d.sens_ot_flag = 1'b1;
            s_d.sens_cnt = '0;
        end
        if (ps.can_ot) begin
            s_d.sensor_control_register[REC_CAN_EN_BIT] = 1'b0;
        end
        if (ps.io_ot && s_q.st != REC_ST_OFF) begin
            s_d.st = REC_ST_STANDBY;
            s_d.mcu_reset_out = 1'b0;
        end

        // Sticky interrupt status
        s_d.irq_stat = s_d.irq_stat | ev;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '{st: REC_ST_OFF, sensor_control_register: REC_SENSOR_CONTROL_REGISTER_RST,
                     device_config_one: REC_DEVICE_CONFIG_ONE_RST, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic rails_on;
    assign rails_on = s_q.st != REC_ST_OFF && s_q.st != REC_ST_STANDBY;
    assign io_rail_en = rails_on;
    assign io_level_5v = !s_q.lvl_open;
    assign core_rail_en = rails_on;
    assign core_gate_drive_en = rails_on && !ps.core_fb_open;
    assign can_rail_en = rails_on && s_q.sensor_control_register[REC_CAN_EN_BIT];
    assign sensor_rail_en = rails_on && s_q.sensor_control_register[REC_SENS_EN_BIT];
    assign sensor_ramp_busy = s_q.sens_cnt != '0;
    assign sensor_tracking = s_q.track;
    assign mcu_reset_out_n = s_q.mcu_reset_out;
    assign core_ov_flag = core_mon && ps.core_ov;
    assign external_stage_enable_out = rails_on && s_q.st != REC_ST_SAFE && !core_ov_flag;
    assign analog_selftest_error = s_q.bist_err;
    assign reg_rdata = s_q.rdata;
    assign irq = |(s_q.irq_stat & s_q.irq_en);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence ot_seen;
        ps.sens_ot;
    endsequence

    sequence ramp_entry;
        s_q.st == REC_ST_OFF && wake_s && !ps.io_ot;
    endsequence

    sequence sens_start;
        reg_wr && reg_addr == REC_SENSOR_CONTROL_REGISTER_ADDR && reg_wdata[REC_SENS_EN_BIT] &&
        !s_q.sensor_control_register[REC_SENS_EN_BIT] && !s_q.sens_ot_flag && !ps.sens_ot;
    endsequence

    sequence flag_read;
        reg_rd && reg_addr == REC_SAFETY_STAT1_ADDR && !ps.sens_ot;
    endsequence

    sequence enable_write;
        reg_wr && reg_addr == REC_SENSOR_CONTROL_REGISTER_ADDR && reg_wdata[REC_SENS_EN_BIT] && !ps.sens_ot;
    endsequence

    io_ot_standby_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ps.io_ot && s_q.st != REC_ST_OFF) |=> !io_rail_en && !core_rail_en)
        else $error("io overtemp did not stop rails");
    sens_ot_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        ot_seen |=> !s_q.sensor_control_register[REC_SENS_EN_BIT] && s_q.sens_ot_flag)
        else $error("sensor overtemp did not clear enable");
    can_ot_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        ps.can_ot |=> !can_rail_en)
        else $error("can overtemp did not clear rail");
    core_open_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        ps.core_fb_open |-> !core_gate_drive_en && !core_ov_flag)
        else $error("open core feedback not masked");
    level_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.latched |=> $stable(io_level_5v))
        else $error("level choice changed after latch");
    track_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.latched |=> $stable(sensor_tracking))
        else $error("tracking choice changed after latch");
    core_uv_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        (core_uv_hit && s_q.st == REC_ST_ACTIVE && !ps.io_ot) |=> !mcu_reset_out_n)
        else $error("core undervoltage did not assert reset");
    sens_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.st == REC_ST_RESET && s_q.sensor_control_register[REC_SENS_EN_BIT] && !ps.sens_ot &&
         !reg_wr) |=> s_q.sensor_control_register[REC_SENS_EN_BIT])
        else $error("sensor enable lost in reset");
    bist_safe_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.st == REC_ST_DIAG && s_q.ramp_cnt != '0 && sensor_rail_en && ps.sens_uv &&
         !ps.io_ot) |=> s_q.st == REC_ST_SAFE && analog_selftest_error)
        else $error("self-test error not raised");
    ramp_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        ramp_entry |=> s_q.st == REC_ST_RAMP)
        else $error("wake did not start ramp");

    // ----------------------------------------
    // Sensor enable and sequence timing checks
    // ----------------------------------------
    sens_ramp_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        sens_start |=> sensor_ramp_busy && s_q.sensor_control_register[REC_SENS_EN_BIT])
        else $error("sensor enable did not start ramp");
    sens_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == REC_SENSOR_CONTROL_REGISTER_ADDR && s_q.sens_ot_flag) |=>
        !s_q.sensor_control_register[REC_SENS_EN_BIT])
        else $error("enable accepted before status read");
    flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        flag_read |=> !s_q.sens_ot_flag)
        else $error("status read did not clear flag");
    sens_reenable_a: assert property (@(posedge clk) disable iff (!rst_n)
        flag_read ##1 !ps.sens_ot ##1 enable_write |=> s_q.sensor_control_register[REC_SENS_EN_BIT])
        else $error("re-enable after status read refused");
    core_uv_extend_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.st == REC_ST_RESET && core_uv_hit && !ps.io_ot) |=>
        s_q.st == REC_ST_RESET && !mcu_reset_out_n)
        else $error("core undervoltage did not extend reset");
    ramp_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        ramp_entry |=> s_q.ramp_cnt == REC_CNT_W'(RAMP_CYC))
        else $error("ramp length not loaded");
    ramp_end_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.st == REC_ST_RAMP && s_q.ramp_cnt == '0 && !ps.io_ot) |=>
        s_q.st == REC_ST_RESET && s_q.latched)
        else $error("ramp did not end in reset");
    selftest_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
        analog_selftest_error |=> analog_selftest_error)
        else $error("self-test error not held");
endmodule
`default_nettype wire

// *** rec_pkg.sv ***
// Package of constants and types for the regulator enable control block
package rec_pkg;

    // ----------------------------------------
    // Register indices on the plain port
    // ----------------------------------------
    localparam logic [3:0] REC_SENSOR_CONTROL_REGISTER_ADDR = 4'h0;
    localparam logic [3:0] REC_DEVICE_CONFIG_ONE_ADDR = 4'h1;
    localparam logic [3:0] REC_SAFETY_STAT1_ADDR = 4'h2;
    localparam logic [3:0] REC_STATUS_ADDR = 4'h3;
    localparam logic [3:0] REC_IRQ_STAT_ADDR = 4'h4;
    localparam logic [3:0] REC_IRQ_EN_ADDR = 4'h5;
    localparam logic [3:0] REC_IRQ_CLR_ADDR = 4'h6;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int REC_SENS_EN_BIT = 0;
    localparam int REC_CAN_EN_BIT = 4;
    localparam int REC_NMASK_BIT = 0;
    localparam int REC_SENS_OT_BIT = 2;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] REC_SENSOR_CONTROL_REGISTER_RST = 8'h10;
    localparam logic [7:0] REC_DEVICE_CONFIG_ONE_RST = 8'h00;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int REC_CLK_HZ = 40_000_000;
    localparam int REC_RAMP_US = 1000;
    localparam int REC_RAMP_CYC = (REC_CLK_HZ / 1_000_000) * REC_RAMP_US;
    localparam int REC_RST_EXT_CYC = 64;
    localparam int REC_BIST_CYC = 32;
    localparam int REC_CNT_W = 16;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        REC_ST_OFF,
        REC_ST_RAMP,
        REC_ST_RESET,
        REC_ST_DIAG,
        REC_ST_ACTIVE,
        REC_ST_SAFE,
        REC_ST_STANDBY
    } rec_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rec_bus_req_t;

    typedef struct packed {
        logic io_ot;
        logic sens_ot;
        logic can_ot;
        logic core_fb_open;
        logic core_uv;
        logic core_ov;
        logic sens_uv;
        logic sens_ov;
        logic level_sel_open;
        logic track_high;
    } rec_pins_t;

endpackage

// *** rec_sync.sv ***
// Two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module rec_sync #(
    parameter int W = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    s1_q[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    s1_q[i] <= d[i];
                    q[i] <= s1_q[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// *** rec_mcu_model.sv ***
// Microcontroller model that reaches the block registers over the plain port
`timescale 1ns/1ps
`default_nettype none
module rec_mcu_model (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    input wire logic mcu_reset_out_n,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    import rec_pkg::*;

    // ----------------------------------------
    // Idle bus at time zero
    // ----------------------------------------
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // ----------------------------------------
    // Bus cycles, released lines show the inverse of the last value
    // ----------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask

    // ----------------------------------------
    // Command sequences
    // ----------------------------------------
    task automatic core_unmask();
        wr(REC_DEVICE_CONFIG_ONE_ADDR, 8'h01);
    endtask

    task automatic sens_write(input logic [7:0] d);
        int i;
        for (i = 0; i < 400 && mcu_reset_out_n !== 1'b1; i++) begin
            @(posedge clk);
        end
        if (i == 400) begin
            rec_top_test.bad_count++;
            $display("[ERR] %0t mcu reset never released for enable", $time);
            rec_top_test.end_sim();
        end else begin
            wr(REC_SENSOR_CONTROL_REGISTER_ADDR, d);
        end
    endtask

    task automatic reenable(output logic [7:0] stat);
        rd(REC_SAFETY_STAT1_ADDR, stat);
        sens_write(8'h11);
    endtask
endmodule
`default_nettype wire

// *** rec_top_test.sv ***
// Self-checking testbench of the regulator enable control block
`timescale 1ns/1ps
`default_nettype none
module rec_top_test;
    import rec_pkg::*;
    localparam int N = 8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wake = 1'b0;
    logic reset_request = 1'b0;
    rec_pins_t pins = '0;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [7:0] v;
    logic reg_wr, reg_rd, io_rail_en, io_level_5v, core_rail_en, core_gate_drive_en;
    logic can_rail_en, sensor_rail_en, sensor_ramp_busy, sensor_tracking, mcu_reset_out_n;
    logic core_ov_flag, external_stage_enable_out, analog_selftest_error, irq;
    int bad_count = 0;
    int checks = 0;

    always #12.5 clk = ~clk;

    rec_top #(.RAMP_CYC(N), .RST_EXT_CYC(N), .BIST_CYC(N)) rec_top_inst (
        .clk(clk), .rst_n(rst_n), .wake(wake), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pins(pins), .reset_request(reset_request), .io_rail_en(io_rail_en),
        .io_level_5v(io_level_5v), .core_rail_en(core_rail_en),
        .core_gate_drive_en(core_gate_drive_en), .can_rail_en(can_rail_en),
        .sensor_rail_en(sensor_rail_en), .sensor_ramp_busy(sensor_ramp_busy),
        .sensor_tracking(sensor_tracking), .mcu_reset_out_n(mcu_reset_out_n),
        .core_ov_flag(core_ov_flag), .external_stage_enable_out(external_stage_enable_out),
        .analog_selftest_error(analog_selftest_error), .irq(irq)
    );

    rec_mcu_model rec_mcu_model_inst (
        .clk(clk), .reg_rdata(reg_rdata), .mcu_reset_out_n(mcu_reset_out_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
        rec_mcu_model_inst.rd(a, v);
        chk(v, exp, what);
    endtask

    task automatic wait_mcu_reset_out();
        for (int i = 0; i < 300; i++) begin
            if (mcu_reset_out_n === 1'b1) return;
            cyc(1);
        end
        bad_count++;
        $display("[ERR] %0t mcu reset never released", $time);
        end_sim();
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("[ERR] %0t run timed out", $time);
        end_sim();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        cyc(1);
        chk(io_rail_en, 8'h00, "io rail before wake");
        chk(sensor_rail_en, 8'h00, "sensor rail at start");
        rchk(REC_SENSOR_CONTROL_REGISTER_ADDR, REC_SENSOR_CONTROL_REGISTER_RST, "sensor control reset");
        rchk(REC_DEVICE_CONFIG_ONE_ADDR, 8'h00, "core unmask reset");
        rec_mcu_model_inst.wr(4'h9, 8'hff);
        rchk(4'h9, 8'h00, "unmapped read");
        $display("test reset values done");
        @(posedge clk) begin
            pins.track_high <= 1'b1;
            wake <= 1'b1;
        end
        cyc(6);
        chk(io_rail_en, 8'h01, "io rail ramp");
        chk(core_rail_en, 8'h01, "core rail ramp");
        chk(mcu_reset_out_n, 8'h00, "reset held in ramp");
        wait_mcu_reset_out();
        rec_mcu_model_inst.core_unmask();
        @(posedge clk) begin
            pins.level_sel_open <= 1'b1;
            pins.track_high <= 1'b0;
        end
        cyc(6);
        chk(io_level_5v, 8'h01, "level latched");
        chk(sensor_tracking, 8'h01, "tracking latched");
        chk(sensor_rail_en, 8'h00, "sensor off before enable");
        $display("test power-up done");
        rec_mcu_model_inst.wr(REC_IRQ_EN_ADDR, 8'h04);
        rec_mcu_model_inst.sens_write(8'h11);
        cyc(1);
        chk(sensor_rail_en, 8'h01, "sensor enabled");
        chk(sensor_ramp_busy, 8'h01, "sensor ramp");
        cyc(N + 2);
        chk(sensor_ramp_busy, 8'h00, "sensor ramp over");
        @(posedge clk) pins.sens_ot <= 1'b1;
        @(posedge clk) pins.sens_ot <= 1'b0;
        cyc(5);
        chk(sensor_rail_en, 8'h00, "sensor off on overtemp");
        chk(can_rail_en, 8'h01, "can kept");
        chk(io_rail_en, 8'h01, "io kept");
        chk(irq, 8'h01, "irq on sensor overtemp");
        rchk(REC_SENSOR_CONTROL_REGISTER_ADDR, 8'h10, "enable bit cleared");
        rchk(REC_IRQ_STAT_ADDR, 8'h04, "irq status");
        rec_mcu_model_inst.wr(REC_SENSOR_CONTROL_REGISTER_ADDR, 8'h11);
        rchk(REC_SENSOR_CONTROL_REGISTER_ADDR, 8'h10, "early enable refused");
        rec_mcu_model_inst.reenable(v);
        chk(v, 8'h04, "overtemp status");
        rchk(REC_SAFETY_STAT1_ADDR, 8'h00, "status cleared by read");
        rchk(REC_SENSOR_CONTROL_REGISTER_ADDR, 8'h11, "re-enabled");
        rec_mcu_model_inst.wr(REC_IRQ_CLR_ADDR, 8'h04);
        cyc(1);
        chk(irq, 8'h00, "irq cleared");
        $display("test sensor overtemp done");
        rec_mcu_model_inst.wr(REC_IRQ_EN_ADDR, 8'h00);
        @(posedge clk) pins.can_ot <= 1'b1;
        @(posedge clk) pins.can_ot <= 1'b0;
        cyc(5);
        chk(can_rail_en, 8'h00, "can off on overtemp");
        chk(sensor_rail_en, 8'h01, "sensor kept");
        chk(irq, 8'h00, "irq masked");
        rchk(REC_SENSOR_CONTROL_REGISTER_ADDR, 8'h01, "can bit cleared");
        rec_mcu_model_inst.wr(REC_IRQ_EN_ADDR, 8'h08);
        cyc(1);
        chk(irq, 8'h01, "irq unmasked");
        rec_mcu_model_inst.wr(REC_IRQ_CLR_ADDR, 8'h08);
        rec_mcu_model_inst.wr(REC_SENSOR_CONTROL_REGISTER_ADDR, 8'h11);
        cyc(1);
        chk(irq, 8'h00, "can irq cleared");
        chk(can_rail_en, 8'h01, "can back");
        $display("test can overtemp done");
        @(posedge clk) pins.core_ov <= 1'b1;
        cyc(5);
        chk(core_ov_flag, 8'h01, "core ov flagged");
        chk(external_stage_enable_out, 8'h00, "stage off on core ov");
        @(posedge clk) pins.core_fb_open <= 1'b1;
        cyc(5);
        chk(core_ov_flag, 8'h00, "core ov masked");
        chk(external_stage_enable_out, 8'h01, "stage kept");
        chk(core_gate_drive_en, 8'h00, "gate low");
        @(posedge clk) begin
            pins.core_ov <= 1'b0;
            pins.core_fb_open <= 1'b0;
            pins.core_uv <= 1'b1;
        end
        cyc(5);
        chk(core_gate_drive_en, 8'h01, "gate back");
        chk(mcu_reset_out_n, 8'h00, "core uv resets");
        chk(sensor_rail_en, 8'h01, "sensor kept in reset");
        @(posedge clk) pins.core_uv <= 1'b0;
        wait_mcu_reset_out();
        rchk(REC_SENSOR_CONTROL_REGISTER_ADDR, 8'h11, "enable survives reset");
        rec_mcu_model_inst.wr(REC_DEVICE_CONFIG_ONE_ADDR, 8'h00);
        @(posedge clk) pins.core_uv <= 1'b1;
        cyc(5);
        chk(mcu_reset_out_n, 8'h01, "core uv masked");
        @(posedge clk) pins.core_uv <= 1'b0;
        $display("test core monitor done");
        cyc(N + 2);
        @(posedge clk) begin
            pins.sens_uv <= 1'b1;
            reset_request <= 1'b1;
        end
        @(posedge clk) reset_request <= 1'b0;
        cyc(40);
        chk(analog_selftest_error, 8'h01, "self-test error");
        chk(external_stage_enable_out, 8'h00, "stage off in safe");
        rec_mcu_model_inst.rd(REC_STATUS_ADDR, v);
        chk({5'h00, v[6:4]}, {5'h00, REC_ST_SAFE}, "safe state");
        @(posedge clk) pins.io_ot <= 1'b1;
        cyc(5);
        chk({io_rail_en, core_rail_en, can_rail_en, sensor_rail_en}, 8'h00, "standby");
        rec_mcu_model_inst.rd(REC_STATUS_ADDR, v);
        chk({5'h00, v[6:4]}, {5'h00, REC_ST_STANDBY}, "standby state");
        @(posedge clk) rst_n <= 1'b0;
        @(posedge clk) rst_n <= 1'b1;
        cyc(1);
        rchk(REC_SENSOR_CONTROL_REGISTER_ADDR, REC_SENSOR_CONTROL_REGISTER_RST, "power-on reset");
        cyc(1);
        chk(io_level_5v, 8'h00, "open pin selects low level");
        $display("test self-test and standby done");
        end_sim();
    end
endmodule
`default_nettype wire
